/* File: rtl/mcu_instruction_execute.sv */
// Purpose: execute unit for a small 8-bit core, issued over apb
// Assumes: pclk 200 MHz, one instruction per write to the instr register
// Notes:
// Functional notes
// - d=0 writes accumulator, d=1 writes file
// - or accumulator with file, zero flag, one cycle
// - copy file to accumulator or itself, zero flag
// - store accumulator to file, no flags
// - accumulator loads option register, no flags
// - pop stack into pc, literal into accumulator
// - rotate left through carry, bit7 to carry
// - rotate right through carry, bit0 to carry
// - sleep clears pd, sets to, clears watchdog
// - file minus accumulator, updates c, dc, z
// - nibble exchange swaps upper and lower halves
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "exec_cfg.svh"
`default_nettype none
module mcu_instruction_execute
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sleep_mode,
  output logic [7:0] option_out
);
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  logic [7:0] acc_reg;
  logic [7:0] option_reg;
  logic [5:0] status_reg;
  logic [`PC_W-1:0] pc_reg;
  logic [`PC_W-1:0] stack_reg [0:1];
  logic [7:0] wdt_reg;
  logic [7:0] prescale_reg;
  logic [7:0] file_mem [0:`FILE_DEPTH-1];
  logic [31:0] prdata_next;
  logic pslverr_next;

  // apb decode
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire file_hit = (paddr[11:6] == 6'(`OFS_FILE_BASE >> 6));
  wire [`FILE_AW-1:0] file_sel = paddr[`FILE_AW+1:2];
  wire hit_instr = (paddr == `OFS_INSTR);
  wire hit_acc = (paddr == `OFS_ACC);
  wire hit_status = (paddr == `OFS_STATUS);
  wire hit_option = (paddr == `OFS_OPTION);
  wire hit_pc = (paddr == `OFS_PC);
  wire hit_stack = (paddr == `OFS_STACK);
  wire hit_wdt = (paddr == `OFS_WATCHDOG);
  wire hit_wake = (paddr == `OFS_WAKE);
  wire mapped = hit_instr | hit_acc | hit_status | hit_option | hit_pc
    | hit_stack | hit_wdt | hit_wake | file_hit;
  wire asleep = status_reg[`ST_SLEEP];

  // instruction fields; while asleep nothing issues
  wire issue = wr & hit_instr & ~asleep;
  wire [3:0] op_raw = pwdata[`INS_OP_LSB+3:`INS_OP_LSB];
  wire dest_file = pwdata[`INS_D_BIT];
  wire [`FILE_AW-1:0] f_addr = pwdata[`INS_F_LSB+`FILE_AW-1:`INS_F_LSB];
  wire [7:0] literal = pwdata[`INS_LIT_LSB+7:`INS_LIT_LSB];
  wire [7:0] fval = file_mem[f_addr];
  wire carry_in = status_reg[`ST_C];
  wire [8:0] diff = {1'b0, fval} - {1'b0, acc_reg};
  wire [4:0] half_diff = {1'b0, fval[3:0]} - {1'b0, acc_reg[3:0]};

  exec_pkg::op_t op;
  logic [7:0] result;
  logic writes_result;
  logic hits_zero;
  logic hits_carry;
  logic new_carry;

  always_comb
  begin
    op = exec_pkg::op_t'(op_raw);
    result = acc_reg;
    writes_result = 1'b0;
    hits_zero = 1'b0;
    hits_carry = 1'b0;
    new_carry = carry_in;
    unique case (op)
      exec_pkg::or_acc_with_file:
      begin
        result = acc_reg | fval;
        writes_result = 1'b1;
        hits_zero = 1'b1;
      end
      exec_pkg::copy_file:
      begin
        result = fval;
        writes_result = 1'b1;
        hits_zero = 1'b1;
      end
      exec_pkg::rotate_left_carry:
      begin
        result = {fval[6:0], carry_in};
        writes_result = 1'b1;
        hits_carry = 1'b1;
        new_carry = fval[7];
      end
      exec_pkg::rotate_right_carry:
      begin
        result = {carry_in, fval[7:1]};
        writes_result = 1'b1;
        hits_carry = 1'b1;
        new_carry = fval[0];
      end
      exec_pkg::subtract_acc_from_file:
      begin
        result = diff[7:0];
        writes_result = 1'b1;
        hits_zero = 1'b1;
        hits_carry = 1'b1;
        new_carry = ~diff[8];
      end
      exec_pkg::nibble_exchange:
      begin
        result = {fval[3:0], fval[7:4]};
        writes_result = 1'b1;
      end
      // the rest write no result and touch no arithmetic flag
      exec_pkg::idle_instruction,
      exec_pkg::store_acc_to_file,
      exec_pkg::load_option,
      exec_pkg::return_with_literal,
      exec_pkg::enter_sleep:
      begin
        result = acc_reg;
      end
      default:
      begin
        result = acc_reg;
      end
    endcase
  end

  wire to_file = writes_result & dest_file;
  wire to_acc = writes_result & ~dest_file;
  wire is_store = (op == exec_pkg::store_acc_to_file);
  wire is_option = (op == exec_pkg::load_option);
  wire is_return = (op == exec_pkg::return_with_literal);
  wire is_sleep = (op == exec_pkg::enter_sleep);

  // accumulator, option register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= 8'h00;
      option_reg <= `OPTION_RST;
    end
    else if (issue)
    begin
      if (to_acc)
        acc_reg <= result;
      else if (is_return)
        acc_reg <= literal;
      if (is_option)
        option_reg <= acc_reg;
    end
    else if (wr & hit_acc)
      acc_reg <= pwdata[7:0];
    else if (wr & hit_option)
      option_reg <= pwdata[7:0];
  end

  // file registers: software writes and result write-back
  always_ff @(posedge pclk)
  begin
    if (issue & to_file)
      file_mem[f_addr] <= result;
    else if (issue & is_store)
      file_mem[f_addr] <= acc_reg;
    else if (wr & file_hit)
      file_mem[file_sel] <= pwdata[7:0];
  end

  // status; flags untouched by store, option, return, idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_reg <= `STATUS_RST;
    else if (issue)
    begin
      if (hits_zero)
        status_reg[`ST_Z] <= is_zero(result);
      if (hits_carry)
        status_reg[`ST_C] <= new_carry;
      if (op == exec_pkg::subtract_acc_from_file)
        status_reg[`ST_DC] <= ~half_diff[4];
      if (is_sleep)
      begin
        status_reg[`ST_PD] <= 1'b0;
        status_reg[`ST_TO] <= 1'b1;
        status_reg[`ST_SLEEP] <= 1'b1;
      end
    end
    else if (wr & hit_wake)
      status_reg[`ST_SLEEP] <= 1'b0;
    else if (wr & hit_status)
      status_reg[`ST_DC:`ST_C] <= pwdata[`ST_DC:`ST_C]; // z is result-only
  end

  // program counter and two-deep return stack
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_reg <= '0;
      stack_reg[0] <= '0;
      stack_reg[1] <= '0;
    end
    else if (issue)
    begin
      if (is_return)
      begin
        pc_reg <= stack_reg[0];
        stack_reg[0] <= stack_reg[1];
      end
      else
        pc_reg <= pc_reg + `PC_W'(1);
    end
    else if (wr & hit_pc)
      pc_reg <= pwdata[`PC_W-1:0];
    else if (wr & hit_stack)
    begin
      stack_reg[0] <= pwdata[`PC_W-1:0];
      stack_reg[1] <= stack_reg[0];
    end
  end

  // watchdog: prescaler gives a one-cycle enable; the stopped oscillator
  // is modelled by freezing both counters while asleep
  wire prescale_tick = (prescale_reg == `PRESCALE_TOP);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_reg <= 8'h00;
      prescale_reg <= 8'h00;
    end
    else if (issue & is_sleep)
    begin
      wdt_reg <= 8'h00;
      prescale_reg <= 8'h00;
    end
    else if (!asleep)
    begin
      prescale_reg <= prescale_reg + 8'h01;
      if (prescale_tick)
        wdt_reg <= wdt_reg + 8'h01;
    end
  end

  // read mux
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    if (hit_acc)
      prdata_next[7:0] = acc_reg;
    else if (hit_status)
      prdata_next[5:0] = status_reg;
    else if (hit_option)
      prdata_next[7:0] = option_reg;
    else if (hit_pc)
      prdata_next[`PC_W-1:0] = pc_reg;
    else if (hit_stack)
      prdata_next[`PC_W-1:0] = stack_reg[0];
    else if (hit_wdt)
      prdata_next[15:0] = {prescale_reg, wdt_reg};
    else if (file_hit)
      prdata_next[7:0] = file_mem[file_sel];
    pslverr_next = ~mapped;
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & pslverr_next;
      prdata <= (psel & penable & ~pready & ~pwrite) ? prdata_next
        : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_mode <= 1'b0;
      option_out <= `OPTION_RST;
    end
    else
    begin
      sleep_mode <= status_reg[`ST_SLEEP];
      option_out <= option_reg;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/exec_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb, one word per register
// Notes: byte addresses throughout
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define OFS_INSTR 12'h000
`define OFS_ACC 12'h004
`define OFS_STATUS 12'h008
`define OFS_OPTION 12'h00C
`define OFS_PC 12'h010
`define OFS_STACK 12'h014
`define OFS_WATCHDOG 12'h018
`define OFS_WAKE 12'h01C
`define OFS_FILE_BASE 12'h040
`define FILE_DEPTH 16
`define FILE_AW 4
`define PC_W 9
`define INS_OP_LSB 0
`define INS_D_BIT 4
`define INS_F_LSB 8
`define INS_LIT_LSB 16
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_PD 3
`define ST_TO 4
`define ST_SLEEP 5
`define STATUS_RST 6'h18
`define OPTION_RST 8'hFF
`define PRESCALE_TOP 8'hFF
`endif

/* File: rtl/exec_pkg.sv */
// Purpose: types shared by the execute block
// Assumes: 4-bit operation code in the instruction word
// Notes: codes not listed are taken as the idle instruction
package exec_pkg;
  typedef enum logic [3:0] {
    idle_instruction,
    or_acc_with_file,
    copy_file,
    store_acc_to_file,
    load_option,
    return_with_literal,
    rotate_left_carry,
    rotate_right_carry,
    enter_sleep,
    subtract_acc_from_file,
    nibble_exchange
  } op_t;
endpackage

/* File: bench/exec_chk.sv */
// Purpose: port checks of the execute block
// Assumes: pready comes two cycles into a transfer
// Notes: sleep_mode and option_out lag by one cycle
`timescale 1ns/1ps
`default_nettype none
module exec_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_mode,
  input wire logic [7:0] option_out
);
  wire tk = psel && penable && pready && pwrite;
  wire slp = tk && paddr == 12'h0 && pwdata[3:0] == 4'h8;
  wire opw = tk && paddr == 12'hC;
  wire opx = opw || tk && paddr == 12'h0 && pwdata[3:0] == 4'h4;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && penable && !pready |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("held");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("err");
  property p_rd0; !pready |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("data");
  property p_opw; opw |-> ##2 option_out == $past(pwdata[7:0], 2); endproperty
  a_opw: assert property (p_opw) else $error("option");
  property p_opc; $changed(option_out) |-> $past(opx, 2); endproperty
  a_opc: assert property (p_opc) else $error("option moved");
  property p_slp; slp |-> ##2 sleep_mode; endproperty
  a_slp: assert property (p_slp) else $error("no sleep");
  property p_slr; $rose(sleep_mode) |-> $past(slp, 2); endproperty
  a_slr: assert property (p_slr) else $error("stray sleep");
  cover property (slp);
  cover property (opx);
  cover property (pslverr);
endmodule
bind mcu_instruction_execute exec_chk u_exec_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .sleep_mode, .option_out);
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: bench for the execute block
// Assumes: every apb wait ends on pready; only the 50000 ns time limit ends a hang
// Notes: file register 1 is reloaded before each table step
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_mode;
  logic [7:0] option_out;
  logic [31:0] rdat;
  logic [31:0] pc0;
  logic rerr;
  logic [47:0] e;
  // op,d,file,acc,status in,result,status out; z carries over, not writable
  logic [47:0] tab [11] = '{48'h10F0_0F00_FF18, 48'h1100_0000_001C,
    48'h205A_0000_5A18, 48'h3111_3C03_3C1B, 48'h6180_0001_0119,
    48'h7002_0001_8118, 48'h9101_1000_F11A, 48'h90F1_F100_001F,
    48'hA03C_0000_C31C, 48'h9110_0103_0F19, 48'h2100_7700_001C};
  int bad_count = 0;
  int n_checks = 0;
  always #2.5 pclk = ~pclk;
  mcu_instruction_execute u_mcu_instruction_execute (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sleep_mode, .option_out);
  task automatic xfer(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmp(input logic [11:0] id, input logic [31:0] x, y);
    n_checks++;
    if (y !== x)
    begin
      bad_count++;
      $display("[FAIL] %h exp %h got %h", id, x, y);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h0, d});
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask
  task automatic ck(input logic [11:0] a, input logic [7:0] x);
    rd(a);
    cmp(a, {24'h0, x}, rdat);
  endtask
  task automatic ins(input logic [3:0] op, input logic d,
    input logic [7:0] k);
    xfer(12'h0, 1'b1, {8'h0, k, 8'h1, 3'h0, d, op});
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #50000;
    bad_count++;
    print_verdict;
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    ck(12'h8, 8'h18);
    ck(12'hC, 8'hFF);
    for (int i = 0; i < 11; i++)
    begin
      e = tab[i];
      wr(12'h44, e[39:32]);
      wr(12'h4, e[31:24]);
      wr(12'h8, e[23:16]);
      ins(e[47:44], e[40], 8'h0);
      ck(e[40] ? 12'h44 : 12'h4, e[15:8]);
      ck(e[40] ? 12'h4 : 12'h44, e[40] ? e[31:24] : e[39:32]);
      ck(12'h8, e[7:0]);
    end
    ins(4'h4, 1'b0, 8'h0);
    ck(12'hC, 8'h77);
    cmp(12'hC, 32'h77, {24'h0, option_out});
    xfer(12'h14, 1'b1, 32'h123);
    ins(4'h5, 1'b0, 8'hA5);
    ck(12'h4, 8'hA5);
    ck(12'h8, 8'h1C);
    rd(12'h10);
    cmp(12'h10, 32'h123, rdat);
    for (int i = 0; i < 2; i++)
    begin
      pc0 = rdat;
      ins(4'(15 * i), 1'b0, 8'h0);
      rd(12'h10);
      cmp(12'h10, pc0 + 32'h1, rdat);
    end
    ck(12'h4, 8'hA5);
    ins(4'h8, 1'b0, 8'h0);
    ck(12'h8, 8'h34);
    ck(12'h18, 8'h0);
    cmp(12'h8, 32'h1, {31'h0, sleep_mode});
    rd(12'h10);
    pc0 = rdat;
    ins(4'h0, 1'b0, 8'h0);
    rd(12'h10);
    cmp(12'h10, pc0, rdat);
    wr(12'h1C, 8'h0);
    rd(12'h20);
    cmp(12'h20, 32'h1, {31'h0, rerr});
    cmp(12'h1C, 32'h0, {31'h0, sleep_mode});
    print_verdict;
  end
endmodule
`default_nettype wire
